// >>> core/serial_segment_handshake.sv
// process-data handshake of a serial I/O module, reached over APB
// assumes a synchronous APB master on ref_clk and a serial framer
// that takes byteOut when byteOutValid and byteOutReady are high
//
// Behaviour
// - falling edge of status reset request sets link ok back to one.
// - while link is faulty, changes to length, tx counter, echo ignored.
// - while link is faulty, clear bits scrub receive or transmit memory.
// - while link is ok, or just recovering, clear requests are refused.
// - after power-up status reads link ok only, counters and length zero.
// - two-bit segment counters step by one and wrap; skips flag loss.
// - link ok reads one while fault-free and zero after a failure.
// - send hold keeps bytes in transmit memory; clear sends a started segment, one byte per 1 us tick.
`timescale 1ns/10ps
`include "seg_handshake_regs.svh"
module serial_segment_handshake (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  // register bus
  input  wire seg_handshake_pkg::apb_req_s apbReq,
  output seg_handshake_pkg::apb_rsp_s     apbRsp,
  // serial side
  output logic [7:0]                      byteOut,
  output logic                            byteOutValid,
  input  wire logic                       byteOutReady,
  input  wire logic                       linkFaultPin,
  // interrupt
  output logic                            irq
);
  import seg_handshake_pkg::*;

  logic [7:0]  ctrlReg;
  logic [7:0]  txLenReg;
  logic        linkOkReg;
  logic [1:0]  rxCntReg;
  logic [1:0]  txEchoReg;
  logic [7:0]  rxLenReg;
  logic [3:0]  irqStatReg;
  logic [3:0]  irqMaskReg;
  logic [7:0]  txMem [`SEG_DEPTH];
  logic [7:0]  rxMem [`SEG_DEPTH];
  logic [3:0]  txWrPtr;
  logic [3:0]  txRdPtr;
  logic [3:0]  rxWrPtr;
  logic [3:0]  rxRdPtr;
  logic [7:0]  txSent;
  logic [7:0]  byteTimer;
  logic        statRstPrev;
  logic        faultMeta;
  logic        faultSync;
  logic [1:0]  txCntSeen;
  logic        rxPending;
  tx_state_e   txState;

  wire wrAcc = apbReq.psel & apbReq.penable & apbReq.pwrite;
  wire rdAcc = apbReq.psel & apbReq.penable & ~apbReq.pwrite;
  wire [11:0] addr = apbReq.paddr;
  wire [7:0]  wb = apbReq.pwdata[7:0];

  wire ctlWr   = wrAcc && addr == `OFS_CONTROL;
  wire lenWr   = wrAcc && addr == `OFS_TX_LENGTH;
  wire dataWr  = wrAcc && addr == `OFS_TX_DATA;
  wire pushWr  = wrAcc && addr == `OFS_RX_PUSH;
  wire stRd    = rdAcc && addr == `OFS_IRQ_STATUS;
  wire rxRd    = rdAcc && addr == `OFS_RX_DATA;
  wire mapped  = addr == `OFS_CONTROL || addr == `OFS_TX_LENGTH ||
                 addr == `OFS_STATUS || addr == `OFS_RX_LENGTH ||
                 addr == `OFS_IRQ_STATUS || addr == `OFS_IRQ_MASK ||
                 addr == `OFS_TX_DATA || addr == `OFS_RX_DATA ||
                 addr == `OFS_FAULT || addr == `OFS_RX_PUSH;

  wire statRstReq = ctrlReg[`CTL_STATRST_BIT];
  wire sendHold   = ctrlReg[`CTL_HOLD_BIT];
  wire [1:0] txCnt  = ctrlReg[`CTL_TXCNT_LSB +: 2];
  wire [1:0] rxEcho = ctrlReg[`CTL_RXECHO_LSB +: 2];
  wire relinkEdge   = statRstPrev & ~statRstReq;
  // refuse clears while ok and in the cycle it recovers
  wire clrAllowed   = ~linkOkReg & ~relinkEdge;
  wire rxClr = clrAllowed & ctrlReg[`CTL_RXCLR_BIT];
  wire txClr = clrAllowed & ctrlReg[`CTL_TXCLR_BIT];
  wire txNewSeg = linkOkReg && txState == TX_IDLE &&
                  txCnt != txCntSeen;
  wire lostSeg  = txNewSeg && txCnt != 2'(txCntSeen + 2'd1);
  wire byteTick = byteTimer == 8'd0;
  wire txHasData = txRdPtr != txWrPtr;

  // apb answers in the access cycle, no wait states
  always_comb begin
    apbRsp.pready  = 1'b1;
    apbRsp.pslverr = apbReq.psel & apbReq.penable & ~mapped;
    apbRsp.prdata  = 32'h0;
    if (addr == `OFS_CONTROL) begin
      apbRsp.prdata = {24'h0, ctrlReg};
    end else if (addr == `OFS_TX_LENGTH) begin
      apbRsp.prdata = {24'h0, txLenReg};
    end else if (addr == `OFS_STATUS) begin
      apbRsp.prdata = {24'h0, linkOkReg, txEchoReg, rxCntReg, 3'h0};
    end else if (addr == `OFS_RX_LENGTH) begin
      apbRsp.prdata = {24'h0, rxLenReg};
    end else if (addr == `OFS_IRQ_STATUS) begin
      apbRsp.prdata = {28'h0, irqStatReg};
    end else if (addr == `OFS_IRQ_MASK) begin
      apbRsp.prdata = {28'h0, irqMaskReg};
    end else if (addr == `OFS_RX_DATA) begin
      // an empty or scrubbed memory reads zero, never a stale byte
      if (rxRdPtr != rxWrPtr) begin
        apbRsp.prdata = {24'h0, rxMem[rxRdPtr]};
      end
    end
  end

  // control byte: counter and echo fields frozen while link faulty
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlReg <= 8'h00;
    end else if (ctlWr) begin
      if (linkOkReg) begin
        ctrlReg <= wb;
      end else begin
        ctrlReg <= {wb[7], ctrlReg[6:3], wb[2:0]};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txLenReg <= 8'h00;
    end else if (lenWr && linkOkReg) begin
      txLenReg <= wb;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      faultMeta <= 1'b0;
      faultSync <= 1'b0;
    end else begin
      faultMeta <= linkFaultPin;
      faultSync <= faultMeta;
    end
  end

  // fault wins only when it is present; the falling request re-arms
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      linkOkReg   <= 1'b1;
      statRstPrev <= 1'b0;
    end else begin
      statRstPrev <= statRstReq;
      if (faultSync || (wrAcc && addr == `OFS_FAULT && wb[0])) begin
        linkOkReg <= 1'b0;
      end else if (relinkEdge) begin
        linkOkReg <= 1'b1;
      end
    end
  end

  // transmit memory written by software, drained by the framer
  always_ff @(posedge ref_clk) begin
    if (dataWr && linkOkReg) begin
      txMem[txWrPtr] <= wb;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txWrPtr <= 4'h0;
    end else if (txClr) begin
      txWrPtr <= 4'h0;
    end else if (dataWr && linkOkReg && 4'(txWrPtr + 4'd1) != txRdPtr) begin
      txWrPtr <= 4'(txWrPtr + 4'd1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      byteTimer <= 8'h00;
    end else if (byteTick) begin
      byteTimer <= 8'(`BYTE_CYCLES - 1);
    end else begin
      byteTimer <= 8'(byteTimer - 8'd1);
    end
  end

  assign byteOut      = txMem[txRdPtr];
  assign byteOutValid = txState == TX_SEND && txHasData &&
                        ~sendHold && byteTick;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txState   <= TX_IDLE;
      txRdPtr   <= 4'h0;
      txSent    <= 8'h00;
      txCntSeen <= 2'b00;
      txEchoReg <= 2'b00;
    end else if (txClr) begin
      txState <= TX_IDLE;
      txRdPtr <= 4'h0;
      txSent  <= 8'h00;
    end else begin
      case (txState)
        TX_IDLE: begin
          if (txNewSeg) begin
            txCntSeen <= txCnt;
            txSent    <= 8'h00;
            txState   <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (txSent >= txLenReg || !txHasData) begin
            txState <= TX_ECHO;
          end else if (byteOutValid && byteOutReady) begin
            txRdPtr <= 4'(txRdPtr + 4'd1);
            txSent  <= 8'(txSent + 8'd1);
          end
        end
        TX_ECHO: begin
          txEchoReg <= txCntSeen;
          txState   <= TX_IDLE;
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  // receive memory: framer bytes arrive through the push register
  always_ff @(posedge ref_clk) begin
    if (pushWr && linkOkReg) begin
      rxMem[rxWrPtr] <= wb;
    end
  end

  // a segment is delivered only once the previous one was echoed
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxWrPtr   <= 4'h0;
      rxRdPtr   <= 4'h0;
      rxCntReg  <= 2'b00;
      rxLenReg  <= 8'h00;
      rxPending <= 1'b0;
    end else if (rxClr) begin
      rxWrPtr   <= 4'h0;
      rxRdPtr   <= 4'h0;
      rxLenReg  <= 8'h00;
      rxPending <= 1'b0;
    end else begin
      if (pushWr && linkOkReg && 4'(rxWrPtr + 4'd1) != rxRdPtr) begin
        rxWrPtr <= 4'(rxWrPtr + 4'd1);
      end
      if (rxRd && rxRdPtr != rxWrPtr) begin
        rxRdPtr <= 4'(rxRdPtr + 4'd1);
      end
      if (rxPending && rxEcho == rxCntReg) begin
        rxPending <= 1'b0;
      end else if (!rxPending && linkOkReg && pushWr && wb[7:0] != 8'h0
                   && apbReq.pwdata[8]) begin
        // bit 8 of a push with a nonzero byte closes the segment
        rxCntReg  <= 2'(rxCntReg + 2'd1);
        rxLenReg  <= 8'(rxWrPtr - rxRdPtr + 4'd1);
        rxPending <= 1'b1;
      end
    end
  end

  // sticky events, read of the status clears; set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatReg <= 4'h0;
      irqMaskReg <= 4'h0;
    end else begin
      if (wrAcc && addr == `OFS_IRQ_MASK) begin
        irqMaskReg <= apbReq.pwdata[3:0];
      end
      irqStatReg <= (stRd ? 4'h0 : irqStatReg) | {
        lostSeg,
        linkOkReg & faultSync,
        txState == TX_ECHO,
        !rxPending && linkOkReg && pushWr && apbReq.pwdata[8]};
    end
  end

  assign irq = |(irqStatReg & irqMaskReg);
endmodule

// >>> core/seg_handshake_regs.svh
// constants of the process-data handshake block
// assumes a 125 MHz core clock and APB with 32-bit data
`ifndef SEG_HANDSHAKE_REGS_SVH
`define SEG_HANDSHAKE_REGS_SVH
`define OFS_CONTROL     12'h000
`define OFS_TX_LENGTH   12'h004
`define OFS_STATUS      12'h008
`define OFS_RX_LENGTH   12'h00c
`define OFS_IRQ_STATUS  12'h010
`define OFS_IRQ_MASK    12'h014
`define OFS_TX_DATA     12'h018
`define OFS_RX_DATA     12'h01c
`define OFS_FAULT       12'h020
`define OFS_RX_PUSH     12'h024
// control byte positions
`define CTL_RXCLR_BIT   0
`define CTL_TXCLR_BIT   1
`define CTL_HOLD_BIT    2
`define CTL_TXCNT_LSB   3
`define CTL_RXECHO_LSB  5
`define CTL_STATRST_BIT 7
// status byte positions
`define ST_RXCNT_LSB    3
`define ST_TXECHO_LSB   5
`define ST_LINKOK_BIT   7
`define STATUS_RESET    8'h80
`define SEG_DEPTH       16
// interrupt bits
`define IRQ_RX_NEW      0
`define IRQ_TX_DONE     1
`define IRQ_FAULT       2
`define IRQ_LOST        3
// time to send one byte: 1 us
`define BYTE_TIME_NS    1000
`define BYTE_CYCLES     ((`BYTE_TIME_NS + 7) / 8)
`endif

// >>> core/seg_handshake_pkg.sv
// types of the process-data handshake block
// constants live in seg_handshake_regs.svh
package seg_handshake_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_ECHO} tx_state_e;
endpackage

// >>> sim/seg_handshake_assertions.sv
// port assertions of the handshake block
// assumes one APB access at a time
`timescale 1ns/10ps
`include "seg_handshake_regs.svh"
module seg_handshake_checker (
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       rst_n,
  // register bus
  input wire seg_handshake_pkg::apb_req_s apbReq,
  input wire seg_handshake_pkg::apb_rsp_s apbRsp,
  // serial side
  input wire logic [7:0]                 byteOut,
  input wire logic                       byteOutValid,
  input wire logic                       byteOutReady,
  input wire logic                       linkFaultPin,
  // interrupt
  input wire logic                       irq
);
  import seg_handshake_pkg::*;
  logic acc, stRd, ctlWr, stRst_reg;
  assign acc   = apbReq.psel && apbReq.penable;
  assign stRd  = acc && !apbReq.pwrite && apbReq.paddr == `OFS_STATUS;
  assign ctlWr = acc && apbReq.pwrite && apbReq.paddr == `OFS_CONTROL;
  // last written status reset request, to spot its falling edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) stRst_reg <= 1'b0;
    else if (ctlWr) stRst_reg <= apbReq.pwdata[7];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_ready; acc |-> apbRsp.pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; acc |-> apbRsp.pslverr == (apbReq.paddr > 12'h024);
  endproperty
  a_err: assert property (p_err) else $error("bad pslverr");
  property p_pulse; byteOutValid |=> !byteOutValid [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_rstq; $rose(rst_n) |-> !irq && !byteOutValid; endproperty
  a_rstq: assert property (p_rstq) else $error("not quiet");
  property p_fault; linkFaultPin [*5] ##0 stRd |-> !apbRsp.prdata[7];
  endproperty
  a_fault: assert property (p_fault) else $error("link ok in fault");
  property p_recov;
    ctlWr && !apbReq.pwdata[7] && stRst_reg && !linkFaultPin ##3 stRd
      |-> apbRsp.prdata[7];
  endproperty
  a_recov: assert property (p_recov) else $error("no recovery");
  property p_stres; stRd |-> apbRsp.prdata[31:8] == 24'h0 &&
    apbRsp.prdata[2:0] == 3'h0; endproperty
  a_stres: assert property (p_stres) else $error("status spare bits");
  property p_irqfall; $fell(irq) |-> $past(acc); endproperty
  a_irqfall: assert property (p_irqfall) else $error("irq fell alone");
  c_tx: cover property (byteOutValid && byteOutReady);
  c_irq: cover property ($rose(irq));
  c_err: cover property (acc && apbRsp.pslverr);
endmodule
bind serial_segment_handshake seg_handshake_checker u_chk (.ref_clk,
  .rst_n, .apbReq, .apbRsp, .byteOut, .byteOutValid, .byteOutReady,
  .linkFaultPin, .irq);

// >>> sim/framer_model.sv
// serial framer model on the far side of the block
// assumes a byte is taken when valid and ready are high together
`timescale 1ns/10ps
module framer_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // serial side
  input  wire logic [7:0] byteOut,
  input  wire logic       byteOutValid,
  output logic            byteOutReady,
  output logic            linkFaultPin,
  // bench control
  input  wire logic       stall,
  input  wire logic       fault,
  output logic [7:0]      lastByte,
  output int              byteCount
);
  assign byteOutReady = !stall;
  assign linkFaultPin = fault;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastByte  <= 8'h00;
      byteCount <= 0;
    end else if (byteOutValid && byteOutReady) begin
      lastByte  <= byteOut;
      byteCount <= byteCount + 1;
    end
  end
endmodule

// >>> sim/tb_serial_segment_handshake.sv
// self-checking bench of the handshake block
// assumes the framer model on the serial side
`timescale 1ns/10ps
`include "seg_handshake_regs.svh"
module tb_serial_segment_handshake;
  import seg_handshake_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        stall = 1'b0;
  logic        fault = 1'b0;
  apb_req_s    req = '0;
  apb_rsp_s    rsp;
  logic [7:0]  byteOut, lastByte;
  logic        byteOutValid, byteOutReady, linkFaultPin, irq;
  int          byteCount, mismatches = 0, checks = 0;
  logic [31:0] rd;
  logic [1:0]  rxc;
  always #4 ref_clk = ~ref_clk;
  serial_segment_handshake u_dut (.ref_clk, .rst_n, .apbReq(req),
    .apbRsp(rsp), .byteOut, .byteOutValid, .byteOutReady, .linkFaultPin,
    .irq);
  framer_model u_frm (.ref_clk, .rst_n, .byteOut, .byteOutValid,
    .byteOutReady, .linkFaultPin, .stall, .fault, .lastByte, .byteCount);
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge ref_clk);
    req.penable <= 1'b1;
    @(posedge ref_clk);
    while (rsp.pready !== 1'b1) @(posedge ref_clk);
    rd = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rdChk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdChk(`OFS_STATUS, 32'h80);
    rdChk(`OFS_RX_LENGTH, 32'h0);
    rdChk(12'h040, 32'h0);
    // five segments so the counter wraps; the mask opens after the first
    for (int i = 1; i <= 5; i++) begin
      apb(1'b1, `OFS_RX_PUSH, 32'h100 | i);
      rxc = 2'(i);
      rdChk(`OFS_STATUS, {24'h0, 3'b100, rxc, 3'b000});
      rdChk(`OFS_RX_LENGTH, 32'h1);
      rdChk(`OFS_RX_DATA, 32'(i));
      chk(irq, i > 1);
      rdChk(`OFS_IRQ_STATUS, 32'h1);
      chk(irq, 1'b0);
      if (i == 1) apb(1'b1, `OFS_IRQ_MASK, 32'hf);
      apb(1'b1, `OFS_CONTROL, {25'h0, rxc, 5'h0});
    end
    apb(1'b1, `OFS_CONTROL, 32'h24);
    apb(1'b1, `OFS_TX_DATA, 32'ha5);
    apb(1'b1, `OFS_TX_DATA, 32'h5a);
    apb(1'b1, `OFS_TX_LENGTH, 32'h2);
    apb(1'b1, `OFS_CONTROL, 32'h2c);
    repeat (300) @(posedge ref_clk);
    chk(byteCount, 0);
    stall <= 1'b1;
    apb(1'b1, `OFS_CONTROL, 32'h28);
    repeat (300) @(posedge ref_clk);
    stall <= 1'b0;
    rd = '0;
    for (int n = 0; n < 2000 && !rd[5]; n++) apb(1'b0, `OFS_STATUS, 0);
    chk(byteCount, 2);
    chk(lastByte, 8'h5a);
    rdChk(`OFS_STATUS, 32'ha8);
    rdChk(`OFS_IRQ_STATUS, 32'h2);
    apb(1'b1, `OFS_RX_PUSH, 32'h33);
    apb(1'b1, `OFS_RX_PUSH, 32'h44);
    apb(1'b1, `OFS_CONTROL, 32'h29);
    apb(1'b1, `OFS_CONTROL, 32'h28);
    rdChk(`OFS_RX_DATA, 32'h33);
    fault <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rdChk(`OFS_STATUS, 32'h28);
    fault <= 1'b0;
    apb(1'b1, `OFS_TX_LENGTH, 32'h7);
    rdChk(`OFS_TX_LENGTH, 32'h2);
    apb(1'b1, `OFS_CONTROL, 32'ha9);
    rdChk(`OFS_RX_DATA, 32'h0);
    apb(1'b1, `OFS_CONTROL, 32'h28);
    rdChk(`OFS_STATUS, 32'ha8);
    wrap_up();
  end
endmodule
